// file: rtl/edge_delay_timer.v
// Purpose: Applies separate rising and falling delays to one enable condition
// Assumes: tick is a one-cycle pulse every 100 us
// Notes: A reversal of the condition during a pending delay restarts it
`timescale 1ns/1ns
module edge_delay_timer #(
  parameter CNT_W = 10
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Timebase
  input wire tick,
  // Condition and delays in ticks
  input wire cond,
  input wire [CNT_W-1:0] rise_ticks,
  input wire [CNT_W-1:0] fall_ticks,
  // Delayed enable
  output reg out_r
);

reg [CNT_W-1:0] cnt_r;
wire [CNT_W-1:0] target;
wire [CNT_W-1:0] cnt_nxt;

assign target = cond ? rise_ticks : fall_ticks;
assign cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};

always @(posedge ref_clk) begin
  if (rst) begin
    out_r <= 1'b0;
    cnt_r <= {CNT_W{1'b0}};
  end else if (cond == out_r) begin
    // Nothing pending; a reversal lands here and clears the count
    cnt_r <= {CNT_W{1'b0}};
  end else if (target == {CNT_W{1'b0}}) begin
    out_r <= cond;
  end else if (tick) begin
    if (cnt_nxt >= target) begin
      out_r <= cond;
      cnt_r <= {CNT_W{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
end

endmodule // edge_delay_timer

// file: rtl/rail_enable_regs.vh
// Purpose: Offsets, fields, reset values and timing for rail enable sequencing
// Assumes: 20 MHz ref_clk, byte-wide register port
// Notes: Definitions only
`ifndef RAIL_ENABLE_REGS_VH
`define RAIL_ENABLE_REGS_VH

// Register offsets
`define SWITCH_A1_ENABLE_DELAYS_OFS 8'h1B
`define REGULATOR_A2_ENABLE_MASKS_OFS 8'h1C
`define REGULATOR_A2_ENABLE_SOURCE_OFS 8'h1D
`define REGULATOR_A2_ENABLE_DELAYS_OFS 8'h1E
`define RAIL_STATUS_OFS 8'h7F

// Reset values
`define SWITCH_A1_ENABLE_DELAYS_RST 8'h00
`define REGULATOR_A2_ENABLE_MASKS_RST 8'h00
`define REGULATOR_A2_ENABLE_SOURCE_RST 8'h40
`define REGULATOR_A2_ENABLE_DELAYS_RST 8'h00

// Field positions
`define TERM_PIN_CHOICE_BIT 6
`define FALL_DELAY_HI 5
`define FALL_DELAY_LO 3
`define RISE_DELAY_HI 2
`define RISE_DELAY_LO 0
`define SOURCE_HI 4
`define SOURCE_LO 2
`define OFF_TIME_HI 7
`define OFF_TIME_LO 6

// Enable source codes
`define SRC_INPUT_1 3'h0
`define SRC_INPUT_2 3'h1
`define SRC_INPUT_5 3'h2
`define SRC_INPUT_4 3'h3
`define SRC_INPUT_3 3'h4
`define SRC_INPUT_3_AND_4 3'h5
`define SRC_INPUT_6 3'h6
`define SRC_ALWAYS 3'h7

// Timing: delay base tick of 100 us
`define CLK_PERIOD_NS 50
`define TICK_PERIOD_NS 100000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICKS_PER_MS 10
`define TICK_CNT_W 11

// Edge delays in ms
`define DLY_CODE1_MS 7'h02
`define DLY_CODE2_MS 7'h04
`define DLY_CODE3_MS 7'h08
`define DLY_CODE4_MS 7'h10
`define DLY_CODE5_MS 7'h18
`define DLY_CODE6_MS 7'h20
`define DLY_CODE7_MS 7'h40

// Regulator A1 off times in ms
`define OFF_CODE0_MS 7'h01
`define OFF_CODE1_MS 7'h05
`define OFF_CODE2_MS 7'h0A
`define OFF_CODE3_MS 7'h64

`endif

// file: rtl/rail_enable_sequencing.v
// Purpose: Enable qualification and sequencing for load switch A1 and regulator A2
// Assumes: Control pins and power-good lines are asynchronous to ref_clk
// Notes: Byte register port at the documented offsets
//
// Operation
// - The termination regulator enable follows control input 3 when bit 6 is 0, input 6 when 1.
// - The switch A1 enable falling edge is delayed per bits 5:3 (none,2,4,8,16,24,32,64 ms).
// - The switch A1 enable rising edge is delayed per bits 2:0 with the same mapping.
// - Each delay need only be within ten percent of nominal.
// - Regulator A2 source bits 1:0 exclude switch B2/regulator A1 and switch B1 power-good.
// - Source field 4:2 selects control input 1, 2, 5, 4, 3 or 6 for codes 0 to 4 and 6.
// - Source code 7 feeds a constant one so no pin is needed.
// - Regulator A2 delays sit at bits 5:3 (fall) and 2:0 (rise): none,2,4,8,16,24,32,64 ms.
// - Bits 7:6 of the regulator A2 delay register set the regulator A1 off time 1/5/10/100 ms.
`timescale 1ns/1ns
`include "rail_enable_regs.vh"
module rail_enable_sequencing #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter CNT_W = `TICK_CNT_W
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  output reg [7:0] reg_rdata_r,
  // Control input pins 1 to 6
  input wire control_input_1,
  input wire control_input_2,
  input wire control_input_3,
  input wire control_input_4,
  input wire control_input_5,
  input wire control_input_6,
  // Power-good of other rails
  input wire [5:0] step_down_power_good,
  input wire switch_a1_power_good,
  input wire regulator_a3_power_good,
  input wire switch_b1_power_good,
  input wire switch_b2_reg_a1_power_good,
  // Switch A1 qualified condition and regulator A1 shutdown request
  input wire switch_a1_enable_cond,
  input wire regulator_a1_shutdown,
  // Rail enables
  output wire switch_a1_enable,
  output wire regulator_a2_enable,
  output wire regulator_a1_off_done,
  output reg termination_enable_r
);

////////////////////////////////////////////////////////////////////////////////
// Delay decode

function [CNT_W-1:0] delay_ticks;
  input [2:0] code;
  reg [6:0] ms;
  reg [31:0] prod;
  begin
    ms = 7'h00;
    case (code)
      3'h1: ms = `DLY_CODE1_MS;
      3'h2: ms = `DLY_CODE2_MS;
      3'h3: ms = `DLY_CODE3_MS;
      3'h4: ms = `DLY_CODE4_MS;
      3'h5: ms = `DLY_CODE5_MS;
      3'h6: ms = `DLY_CODE6_MS;
      3'h7: ms = `DLY_CODE7_MS;
      default: ms = 7'h00;
    endcase
    // Longest product is 640 ticks, inside CNT_W
    prod = ms * `TICKS_PER_MS;
    delay_ticks = prod[CNT_W-1:0];
  end
endfunction

function [CNT_W-1:0] off_ticks;
  input [1:0] code;
  reg [6:0] ms;
  reg [31:0] prod;
  begin
    ms = 7'h00;
    case (code)
      2'h0: ms = `OFF_CODE0_MS;
      2'h1: ms = `OFF_CODE1_MS;
      2'h2: ms = `OFF_CODE2_MS;
      default: ms = `OFF_CODE3_MS;
    endcase
    // Longest product is 1000 ticks, inside CNT_W
    prod = ms * `TICKS_PER_MS;
    off_ticks = prod[CNT_W-1:0];
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] sw_a1_delays_r;
reg [7:0] a2_masks_r;
reg [7:0] a2_source_r;
reg [7:0] a2_delays_r;
reg a2_cond_r;
wire [7:0] status;

always @(posedge ref_clk) begin
  if (rst) begin
    sw_a1_delays_r <= `SWITCH_A1_ENABLE_DELAYS_RST;
    a2_masks_r <= `REGULATOR_A2_ENABLE_MASKS_RST;
    a2_source_r <= `REGULATOR_A2_ENABLE_SOURCE_RST;
    a2_delays_r <= `REGULATOR_A2_ENABLE_DELAYS_RST;
  end else if (reg_wr) begin
    case (reg_addr)
      `SWITCH_A1_ENABLE_DELAYS_OFS: sw_a1_delays_r <= reg_wdata;
      `REGULATOR_A2_ENABLE_MASKS_OFS: a2_masks_r <= reg_wdata;
      `REGULATOR_A2_ENABLE_SOURCE_OFS: a2_source_r <= reg_wdata;
      `REGULATOR_A2_ENABLE_DELAYS_OFS: a2_delays_r <= reg_wdata;
      default: ;
    endcase
  end
end

assign status = {2'h0, a2_cond_r, switch_a1_enable_cond, termination_enable_r,
                 regulator_a1_off_done, regulator_a2_enable, switch_a1_enable};

always @(posedge ref_clk) begin
  if (rst) begin
    reg_rdata_r <= 8'h00;
  end else begin
    case (reg_addr)
      `SWITCH_A1_ENABLE_DELAYS_OFS: reg_rdata_r <= sw_a1_delays_r;
      `REGULATOR_A2_ENABLE_MASKS_OFS: reg_rdata_r <= a2_masks_r;
      `REGULATOR_A2_ENABLE_SOURCE_OFS: reg_rdata_r <= a2_source_r;
      `REGULATOR_A2_ENABLE_DELAYS_OFS: reg_rdata_r <= a2_delays_r;
      `RAIL_STATUS_OFS: reg_rdata_r <= status;
      default: reg_rdata_r <= 8'h00;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers

localparam IN_W = 16;
wire [IN_W-1:0] raw_in;
reg [IN_W-1:0] sync1_r;
reg [IN_W-1:0] sync2_r;
reg [IN_W-1:0] sync3_r;
reg [IN_W-1:0] filt_r;

assign raw_in = {switch_b2_reg_a1_power_good, switch_b1_power_good,
                 regulator_a3_power_good, switch_a1_power_good, step_down_power_good,
                 control_input_6, control_input_5, control_input_4,
                 control_input_3, control_input_2, control_input_1};

genvar gi;
generate
  for (gi = 0; gi < IN_W; gi = gi + 1) begin : g_sync
    always @(posedge ref_clk) begin
      if (rst) begin
        sync1_r[gi] <= 1'b0;
        sync2_r[gi] <= 1'b0;
        sync3_r[gi] <= 1'b0;
        filt_r[gi] <= 1'b0;
      end else begin
        sync1_r[gi] <= raw_in[gi];
        sync2_r[gi] <= sync1_r[gi];
        sync3_r[gi] <= sync2_r[gi];
        if (sync2_r[gi] == sync3_r[gi]) begin
          filt_r[gi] <= sync3_r[gi];
        end
      end
    end
  end
endgenerate

wire [5:0] ctl;
wire [9:0] pg;
assign ctl = filt_r[5:0];
assign pg = filt_r[15:6];

////////////////////////////////////////////////////////////////////////////////
// Termination enable and regulator A2 qualification

reg src_sel;
wire [9:0] pg_mask;
wire pg_ok;

always @(posedge ref_clk) begin
  if (rst) begin
    termination_enable_r <= 1'b0;
  end else begin
    termination_enable_r <= sw_a1_delays_r[`TERM_PIN_CHOICE_BIT] ? ctl[5] : ctl[2];
  end
end

always @* begin
  src_sel = 1'b0;
  case (a2_source_r[`SOURCE_HI:`SOURCE_LO])
    `SRC_INPUT_1: src_sel = ctl[0];
    `SRC_INPUT_2: src_sel = ctl[1];
    `SRC_INPUT_5: src_sel = ctl[4];
    `SRC_INPUT_4: src_sel = ctl[3];
    `SRC_INPUT_3: src_sel = ctl[2];
    `SRC_INPUT_3_AND_4: src_sel = ctl[2] & ctl[3];
    `SRC_INPUT_6: src_sel = ctl[5];
    `SRC_ALWAYS: src_sel = 1'b1;
    default: src_sel = 1'b0;
  endcase
end

assign pg_mask = {a2_source_r[1:0], a2_masks_r};
assign pg_ok = &(pg | pg_mask);

always @(posedge ref_clk) begin
  if (rst) begin
    a2_cond_r <= 1'b0;
  end else begin
    a2_cond_r <= src_sel & pg_ok;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Delay timebase and timers

reg [12:0] div_r;
reg tick_r;

// Exact 100 us tick keeps a 2 ms delay within 5 percent
always @(posedge ref_clk) begin
  if (rst) begin
    div_r <= 13'h0000;
    tick_r <= 1'b0;
  end else if (div_r == TICK_CYCLES[12:0] - 13'h0001) begin
    div_r <= 13'h0000;
    tick_r <= 1'b1;
  end else begin
    div_r <= div_r + 13'h0001;
    tick_r <= 1'b0;
  end
end

edge_delay_timer #(.CNT_W(CNT_W)) u_switch_a1 (
  .ref_clk(ref_clk),
  .rst(rst),
  .tick(tick_r),
  .cond(switch_a1_enable_cond),
  .rise_ticks(delay_ticks(sw_a1_delays_r[`RISE_DELAY_HI:`RISE_DELAY_LO])),
  .fall_ticks(delay_ticks(sw_a1_delays_r[`FALL_DELAY_HI:`FALL_DELAY_LO])),
  .out_r(switch_a1_enable)
);

edge_delay_timer #(.CNT_W(CNT_W)) u_regulator_a2 (
  .ref_clk(ref_clk),
  .rst(rst),
  .tick(tick_r),
  .cond(a2_cond_r),
  .rise_ticks(delay_ticks(a2_delays_r[`RISE_DELAY_HI:`RISE_DELAY_LO])),
  .fall_ticks(delay_ticks(a2_delays_r[`FALL_DELAY_HI:`FALL_DELAY_LO])),
  .out_r(regulator_a2_enable)
);

edge_delay_timer #(.CNT_W(CNT_W)) u_regulator_a1_off (
  .ref_clk(ref_clk),
  .rst(rst),
  .tick(tick_r),
  .cond(regulator_a1_shutdown),
  .rise_ticks(off_ticks(a2_delays_r[`OFF_TIME_HI:`OFF_TIME_LO])),
  .fall_ticks({CNT_W{1'b0}}),
  .out_r(regulator_a1_off_done)
);

endmodule // rail_enable_sequencing

// file: tb/board_model.sv
// Purpose: Board control pins and sibling rail power-good
// Assumes: Levels requested by the bench
// Notes: Pins move off the clock grid, as on a real board
`timescale 1ns/1ns
module board_model (
  // Requests
  input wire [5:0] pin_req,
  input wire [9:0] pg_req,
  // Pins and power-good
  output wire [5:0] pins,
  output wire [9:0] pg
);
  // Continuous so the levels follow the requests 7 ns (pins) and 11 ns (pg) later
  assign #7 pins = pin_req;
  assign #11 pg = pg_req;
endmodule // board_model

// file: tb/rail_enable_sequencing_assertions.sv
// Purpose: Port checks for rail enable sequencing
// Assumes: Ten delay ticks of TICK_CYCLES clocks per ms
// Notes: Bound to rail_enable_sequencing by the bind below
`timescale 1ns/1ns
module rail_enable_sequencing_assertions #(
  parameter TICK_CYCLES = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire [7:0] reg_rdata_r,
  // Pins and conditions
  input wire control_input_3,
  input wire control_input_6,
  input wire switch_a1_enable_cond,
  input wire regulator_a1_shutdown,
  // Enables
  input wire switch_a1_enable,
  input wire regulator_a2_enable,
  input wire regulator_a1_off_done,
  input wire termination_enable_r
);
  int up_n;
  int dn_n;
  int off_n;
  logic cond_d;
  logic [7:0] sw_r;
  wire sel_pin = sw_r[6] ? control_input_6 : control_input_3;
  // Shortest legal delay in clocks, with pipeline slack
  function automatic int lo_ms(input logic [2:0] c);
    int t[8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    return (t[c] * 10 - 1) * TICK_CYCLES - 2;
  endfunction
  always @(posedge ref_clk) begin
    cond_d <= switch_a1_enable_cond;
    up_n <= (switch_a1_enable_cond && !cond_d) ? 0 : up_n + 1;
    dn_n <= (!switch_a1_enable_cond && cond_d) ? 0 : dn_n + 1;
    off_n <= regulator_a1_shutdown ? off_n + 1 : 0;
    if (rst)
      sw_r <= 8'h00;
    else if (reg_wr && reg_addr == 8'h1B)
      sw_r <= reg_wdata;
  end
  //////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_reset_low;
    $fell(rst) |-> !(switch_a1_enable || regulator_a2_enable || termination_enable_r);
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("enable high after reset");
  property p_off_clear;
    !regulator_a1_shutdown |=> !regulator_a1_off_done;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("off done not cleared");
  property p_off_min;
    $rose(regulator_a1_off_done) |-> off_n >= 9 * TICK_CYCLES - 2;
  endproperty
  a_off_min: assert property (p_off_min) else $error("off time too short");
  property p_sw_rise;
    $rose(switch_a1_enable) |-> up_n >= lo_ms(sw_r[2:0]);
  endproperty
  a_sw_rise: assert property (p_sw_rise) else $error("rise delay too short");
  property p_sw_fall;
    $fell(switch_a1_enable) |-> dn_n >= lo_ms(sw_r[5:3]);
  endproperty
  a_sw_fall: assert property (p_sw_fall) else $error("fall delay too short");
  property p_term_hi;
    sel_pin [*8] |-> termination_enable_r;
  endproperty
  a_term_hi: assert property (p_term_hi) else $error("termination not on");
  property p_term_lo;
    !sel_pin [*8] |-> !termination_enable_r;
  endproperty
  a_term_lo: assert property (p_term_lo) else $error("termination not off");
  property p_sw_read;
    !reg_wr && reg_addr == 8'h1B |=> reg_rdata_r == sw_r;
  endproperty
  a_sw_read: assert property (p_sw_read) else $error("delay register readback");
  c_sw_rise: cover property ($rose(switch_a1_enable));
  c_off: cover property ($rose(regulator_a1_off_done));
  c_term: cover property ($rose(termination_enable_r));
endmodule // rail_enable_sequencing_assertions

bind rail_enable_sequencing rail_enable_sequencing_assertions #(
  .TICK_CYCLES(TICK_CYCLES)
) i_rail_enable_sequencing_assertions (
  .ref_clk(ref_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rdata_r(reg_rdata_r),
  .control_input_3(control_input_3),
  .control_input_6(control_input_6),
  .switch_a1_enable_cond(switch_a1_enable_cond),
  .regulator_a1_shutdown(regulator_a1_shutdown),
  .switch_a1_enable(switch_a1_enable),
  .regulator_a2_enable(regulator_a2_enable),
  .regulator_a1_off_done(regulator_a1_off_done),
  .termination_enable_r(termination_enable_r)
);

// file: tb/rail_enable_sequencing_tb_top.sv
// Purpose: Self-checking bench for rail enable sequencing
// Assumes: TICK_CYCLES of 4, so 1 ms is 40 clocks
// Notes: Pins 0..5 are control inputs 1..6
`timescale 1ns/1ns
module rail_enable_sequencing_tb_top;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic cond = 1'h0;
  logic shut = 1'h0;
  logic [5:0] pin_req = 6'h00;
  logic [9:0] pg_req = 10'h3FF;
  logic [5:0] sel[8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};
  wire [5:0] pins;
  wire [9:0] pg;
  wire [7:0] reg_rdata_r;
  wire [3:0] outs;
  int num_errors = 0;
  int checked = 0;
  always #25 ref_clk = ~ref_clk;
  board_model i_board_model (.pin_req(pin_req), .pg_req(pg_req), .pins(pins), .pg(pg));
  rail_enable_sequencing #(
    .TICK_CYCLES(4)
  ) i_rail_enable_sequencing (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rdata_r(reg_rdata_r),
    .control_input_1(pins[0]),
    .control_input_2(pins[1]),
    .control_input_3(pins[2]),
    .control_input_4(pins[3]),
    .control_input_5(pins[4]),
    .control_input_6(pins[5]),
    .step_down_power_good(pg[5:0]),
    .switch_a1_power_good(pg[6]),
    .regulator_a3_power_good(pg[7]),
    .switch_b2_reg_a1_power_good(pg[8]),
    .switch_b1_power_good(pg[9]),
    .switch_a1_enable_cond(cond),
    .regulator_a1_shutdown(shut),
    .switch_a1_enable(outs[0]),
    .regulator_a2_enable(outs[1]),
    .regulator_a1_off_done(outs[2]),
    .termination_enable_r(outs[3])
  );
  //////////////////////////////////////
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(posedge ref_clk);
    #2 reg_wr = 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    #2 reg_addr = a;
    @(posedge ref_clk);
    #1 checked++;
    if (reg_rdata_r !== e) begin
      num_errors++;
      $display("MISMATCH rdata %h exp %h got %h", a, e, reg_rdata_r);
    end
  endtask
  // Waits for an output level, then judges value and delay in ms
  task wt(input string n, input int i, input logic v, input int ms);
    int c;
    c = 0;
    while (outs[i] !== v && c < ms * 40 + 40) begin
      @(posedge ref_clk);
      #2 c++;
    end
    checked++;
    if (outs[i] !== v || c < ms * 40 - 4) begin
      num_errors++;
      $display("MISMATCH %s exp %b after %0d got %b after %0d", n, v, ms * 40, outs[i], c);
    end
  endtask
  // Lets a pin change clear the input filter before a level is judged
  task settle;
    repeat (10) @(posedge ref_clk);
    #2;
  endtask
  task t_regs;
    rd(8'h1B, 8'h00);
    rd(8'h1C, 8'h00);
    rd(8'h1D, 8'h40);
    rd(8'h1E, 8'h00);
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    wr(8'h1E, 8'hA5);
    rd(8'h1E, 8'hA5);
    $display("test regs done");
  endtask
  task t_term;
    wr(8'h1B, 8'h00);
    pin_req = 6'h04;
    wt("term control_input_3", 3, 1'h1, 0);
    wr(8'h1B, 8'h40);
    wt("term control_input_6 low", 3, 1'h0, 0);
    pin_req = 6'h20;
    wt("term control_input_6", 3, 1'h1, 0);
    $display("test term done");
  endtask
  task t_src;
    wr(8'h1C, 8'hFF);
    wr(8'h1E, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(8'h1D, {3'h0, k[2:0], 2'h3});
      pin_req = ~sel[k];
      settle;
      wt("src off", 1, k == 7, 0);
      pin_req = sel[k];
      wt("src on", 1, 1'h1, 0);
    end
    wr(8'h1D, 8'h17);
    pin_req = 6'h04;
    settle;
    wt("src control_input_3 only", 1, 1'h0, 0);
    $display("test src done");
  endtask
  task t_mask;
    wr(8'h1D, 8'h1C);
    wr(8'h1C, 8'h00);
    for (int i = 0; i < 10; i++) begin
      pg_req[i] = 1'h0;
      wt("pg drop", 1, 1'h0, 0);
      if (i < 8)
        wr(8'h1C, 8'h01 << i);
      else
        wr(8'h1D, i == 8 ? 8'h1E : 8'h1D);
      wt("pg masked", 1, 1'h1, 0);
      pg_req = 10'h3FF;
      wr(8'h1C, 8'h00);
      wr(8'h1D, 8'h1C);
      settle;
    end
    $display("test mask done");
  endtask
  task t_a2dly;
    wr(8'h1E, 8'h31);
    pin_req = 6'h00;
    wr(8'h1D, 8'h03);
    wt("a2 idle", 1, 1'h0, 32);
    pin_req = 6'h01;
    repeat (40) @(posedge ref_clk);
    #2 pin_req = 6'h00;
    repeat (20) @(posedge ref_clk);
    #2 pin_req = 6'h01;
    wt("a2 rise", 1, 1'h1, 2);
    pin_req = 6'h00;
    wt("a2 fall", 1, 1'h0, 32);
    $display("test a2 delay done");
  endtask
  task t_sw;
    wr(8'h1B, 8'h3D);
    cond = 1'h1;
    wt("sw rise", 0, 1'h1, 24);
    cond = 1'h0;
    wt("sw fall", 0, 1'h0, 64);
    $display("test switch done");
  endtask
  task t_off;
    int t[4] = '{1, 5, 10, 100};
    for (int k = 0; k < 4; k++) begin
      wr(8'h1E, {k[1:0], 6'h00});
      shut = 1'h1;
      wt("off time", 2, 1'h1, t[k]);
      shut = 1'h0;
      wt("off clear", 2, 1'h0, 0);
    end
    $display("test off time done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #2 rst = 1'h0;
    t_regs;
    t_term;
    t_src;
    t_mask;
    t_a2dly;
    t_sw;
    t_off;
    end_of_test;
  end
  initial begin
    #2000000 num_errors++;
    $display("watchdog expired");
    end_of_test;
  end
endmodule // rail_enable_sequencing_tb_top
